// [rtl/msf_core.v]
/*
 * Measurement sequencing and filter core: mode control, emission staggering,
 * cycle length report, gain, median spike filter and power-of-two average,
 * with an Avalon-MM register slave and an output FIFO.
 * Assumes one raw sample per measurement cycle from the front end on the
 * same clock, and a downstream stage that may stall through resultReady.
 */
`timescale 1ns/100ps
`include "msf_defs.vh"
module msf_core (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire [3:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWriteData,
    input  wire [3:0]  avsByteEnable,
    output reg  [31:0] avsReadData,
    output wire        avsWaitRequest,
    input  wire        sampleValid,
    output wire        sampleReady,
    input  wire [23:0] sampleData,
    input  wire [15:0] regularCycle,
    input  wire        teachDone,
    input  wire        teachOk,
    input  wire [9:0]  teachSplit,
    output reg         teachStart,
    output reg  [9:0]  laserLower,
    output reg  [9:0]  laserUpper,
    output reg         laserSweep,
    output reg         sectionMode,
    output reg  [9:0]  sectionSplit,
    output reg         staggerOn,
    output reg         staggerSlot,
    output reg  [2:0]  sensorGain,
    output wire        resultValid,
    input  wire        resultReady,
    output wire [23:0] resultData
);
    localparam DW = `MSF_DATA_W;
    localparam MD = `MSF_MEDIAN_DEPTH;
    localparam ST_IDLE  = 2'h0;
    localparam ST_TEACH = 2'h1;
    localparam ST_WAIT  = 2'h2;

    reg  [1:0]    objSel;
    reg  [2:0]    senseMode;
    reg  [9:0]    boundLo;
    reg  [9:0]    boundHi;
    reg           smoothOn;
    reg  [3:0]    avgLog;
    reg  [1:0]    teachState;
    reg           teachFail;
    reg  [31:0]   cycleLen;
    reg           ackPhase;
    reg  [DW-1:0] window [0:MD-1];
    reg  [DW-1:0] medianVal;
    reg  [DW-1:0] filtered;
    reg           filtValid;
    reg  [DW-1:0] avgRing [0:4095];
    reg  [11:0]   ringPtr;
    reg  [35:0]   avgSum;
    reg  [DW-1:0] avgOut;
    wire [DW-1:0] evict;
    reg           avgValid;
    reg  [12:0]   avgFill;
    reg           staggerSet;
    wire [12:0]   avgCount;
    wire [35:0]   nextSum;
    wire [35:0]   meanFull;
    wire          avgClear;
    wire          fifoInReady;
    wire          depthSel;
    wire          regWr;
    wire          take;
    integer       i;
    integer       j;
    integer       below;
    integer       same;
    integer       w;

    function [9:0] clampLaser;
        input [9:0] v;
        begin
            if (v < `MSF_LASER_MIN) begin
                clampLaser = `MSF_LASER_MIN;
            end else if (v > `MSF_LASER_MAX) begin
                clampLaser = `MSF_LASER_MAX;
            end else begin
                clampLaser = v;
            end
        end
    endfunction

    // One access per two cycles keeps the slave simple; waitrequest drops on the second.
    assign avsWaitRequest = (avsRead | avsWrite) & ~ackPhase;
    assign regWr          = avsWrite & ackPhase;
    assign depthSel       = (objSel != `MSF_OBJ_NORMAL);
    // One sample in flight at most, so a FIFO slot free at acceptance is still free at push.
    assign sampleReady    = fifoInReady & ~filtValid & ~avgValid;
    assign take           = sampleValid & sampleReady;
    assign avgClear       = regWr & (avsAddress == `MSF_REG_FILTER) & avsByteEnable[0];
    assign avgCount       = 13'h0001 << avgLog;
    // Until the window has filled, missing samples count as zero in the mean.
    assign evict          = (avgFill < avgCount) ? {DW{1'b0}} : avgRing[ringPtr - avgCount[11:0]];
    assign nextSum        = avgSum + {12'h0, filtered} - {12'h0, evict};
    assign meanFull       = nextSum >> avgLog;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ackPhase    <= 1'b0;
            avsReadData <= 32'h0;
        end else begin
            ackPhase <= (avsRead | avsWrite) & ~ackPhase;
            if (avsRead && !ackPhase) begin
                case (avsAddress)
                    `MSF_REG_CTRL:   avsReadData <= {23'h0, teachState == ST_WAIT, 1'b0,
                                                     senseMode, staggerSlot, staggerSet,
                                                     objSel};
                    `MSF_REG_LASER:  avsReadData <= {6'h0, boundHi, 6'h0, boundLo};
                    `MSF_REG_GAIN:   avsReadData <= {29'h0, sensorGain};
                    `MSF_REG_FILTER: avsReadData <= {24'h0, avgLog, 3'h0, smoothOn};
                    `MSF_REG_AREA:   avsReadData <= {21'h0, sectionMode, sectionSplit};
                    `MSF_REG_CYCLE:  avsReadData <= cycleLen;                     // [RULE_11]
                    `MSF_REG_STATUS: avsReadData <= {30'h0, teachFail, laserSweep};
                    `MSF_REG_RESULT: avsReadData <= {8'h0, avgOut};
                    default:         avsReadData <= 32'h0;
                endcase
            end
        end
    end

    // Control registers; an illegal value is clamped into the documented range.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            objSel      <= `MSF_OBJ_NORMAL;
            senseMode   <= `MSF_MODE_BASELINE;
            staggerSet  <= 1'b0;                                              // [RULE_08]
            staggerSlot <= 1'b0;
            boundLo     <= `MSF_LASER_MIN;                                    // [RULE_03]
            boundHi     <= `MSF_LASER_MAX;
            sensorGain  <= `MSF_GAIN_MIN;                                     // [RULE_12]
            smoothOn    <= `MSF_SMOOTH_RST;                                   // [RULE_13]
            avgLog      <= `MSF_AVG_LOG_RST;                                  // [RULE_15]
        end else if (regWr) begin
            case (avsAddress)
                `MSF_REG_CTRL: if (avsByteEnable[0]) begin
                    objSel      <= avsWriteData[1:0] > `MSF_OBJ_DEPTH_MOVE ?
                                   `MSF_OBJ_DEPTH_MOVE : avsWriteData[1:0];
                    staggerSet  <= avsWriteData[`MSF_CTRL_SYNC_ON];           // [RULE_08]
                    staggerSlot <= avsWriteData[`MSF_CTRL_SYNC_SLOT];
                    senseMode   <= avsWriteData[6:4] > `MSF_MODE_USER ?
                                   `MSF_MODE_USER : avsWriteData[6:4];
                end
                `MSF_REG_LASER: if (&avsByteEnable) begin
                    boundLo <= clampLaser(avsWriteData[9:0]);                 // [RULE_03]
                    boundHi <= clampLaser(avsWriteData[25:16]);
                end
                `MSF_REG_GAIN: if (avsByteEnable[0]) begin
                    if (avsWriteData[2:0] < `MSF_GAIN_MIN) begin
                        sensorGain <= `MSF_GAIN_MIN;                          // [RULE_12]
                    end else if (avsWriteData[2:0] > `MSF_GAIN_MAX) begin
                        sensorGain <= `MSF_GAIN_MAX;
                    end else begin
                        sensorGain <= avsWriteData[2:0];
                    end
                end
                `MSF_REG_FILTER: if (avsByteEnable[0]) begin
                    smoothOn <= avsWriteData[`MSF_FLT_SMOOTH];                // [RULE_14]
                    avgLog   <= avsWriteData[7:4] > `MSF_AVG_LOG_MAX ?
                                `MSF_AVG_LOG_MAX : avsWriteData[7:4];         // [RULE_15]
                end
                default: ;
            endcase
        end
    end

    // Effective front-end settings and cycle length, recomputed every cycle.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            laserLower  <= `MSF_LASER_MIN;
            laserUpper  <= `MSF_LASER_MAX;
            laserSweep  <= 1'b0;
            staggerOn   <= 1'b0;
            cycleLen    <= 32'h0;
        end else begin
            laserLower <= boundLo;
            staggerOn  <= staggerSet & ~depthSel;                             // [RULE_04]
            laserSweep <= (objSel == `MSF_OBJ_DEPTH_STOP);                    // [RULE_01]
            if (objSel == `MSF_OBJ_DEPTH_STOP && boundHi > `MSF_LASER_SWEEP_MAX) begin
                laserUpper <= `MSF_LASER_SWEEP_MAX;                           // [RULE_02]
            end else begin
                laserUpper <= boundHi;
            end
            if (objSel == `MSF_OBJ_DEPTH_STOP) begin
                // Lowering the upper bound below 20 percent shortens the sweep proportionally.
                cycleLen <= ({16'h0, regularCycle} * `MSF_SWEEP_FACTOR *
                             (boundHi < `MSF_LASER_SWEEP_MAX ? boundHi : `MSF_LASER_SWEEP_MAX))
                            / `MSF_LASER_SWEEP_MAX;                           // [RULE_01] [RULE_02]
            end else if (staggerSet && !depthSel) begin                       // [RULE_04]
                cycleLen <= {16'h0, regularCycle} * (senseMode == `MSF_MODE_FAST ?
                            `MSF_SYNC_FACT_FAST : `MSF_SYNC_FACTOR);          // [RULE_09]
            end else begin
                cycleLen <= {16'h0, regularCycle};
            end
        end
    end

    // Teaching sequence for moving two-surface mode.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            teachState   <= ST_IDLE;
            teachStart   <= 1'b0;
            teachFail    <= 1'b0;
            sectionMode  <= 1'b0;
            sectionSplit <= 10'h0;
        end else begin
            teachStart <= 1'b0;
            case (teachState)
                ST_IDLE: begin
                    if (regWr && avsAddress == `MSF_REG_CTRL && avsByteEnable[0] &&
                        avsWriteData[1:0] == `MSF_OBJ_DEPTH_MOVE) begin
                        teachState <= ST_TEACH;                               // [RULE_06]
                    end else if (objSel != `MSF_OBJ_DEPTH_MOVE) begin
                        sectionMode <= 1'b0;
                    end
                end
                ST_TEACH: begin
                    teachStart <= 1'b1;
                    teachState <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (teachDone) begin
                        teachState  <= ST_IDLE;
                        teachFail   <= ~teachOk;
                        sectionMode <= teachOk;                               // [RULE_05]
                        sectionSplit <= teachOk ? teachSplit : 10'h0;         // [RULE_06] [RULE_07]
                    end
                end
                default: teachState <= ST_IDLE;
            endcase
        end
    end

    // Window of the fifteen latest samples; cleared at reset so early medians are zero.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (w = 0; w < MD; w = w + 1) begin
                window[w] <= {DW{1'b0}};
            end
            filtValid <= 1'b0;
        end else begin
            filtValid <= take;
            if (take) begin
                window[0] <= sampleData;
                for (w = 1; w < MD; w = w + 1) begin
                    window[w] <= window[w-1];
                end
            end
        end
    end

    // A value with at most seven smaller entries and enough equal ones is the median.
    always @* begin
        medianVal = window[0];
        below     = 0;
        same      = 0;
        for (i = 0; i < MD; i = i + 1) begin
            below = 0;
            same  = 0;
            for (j = 0; j < MD; j = j + 1) begin
                if (window[j] < window[i]) begin
                    below = below + 1;
                end else if (window[j] == window[i]) begin
                    same = same + 1;
                end
            end
            if (below <= MD / 2 && below + same > MD / 2) begin
                medianVal = window[i];                                        // [RULE_13]
            end
        end
        filtered = smoothOn ? medianVal : window[0];                          // [RULE_13] [RULE_14]
    end

    always @(posedge clk_sys) begin
        if (filtValid) begin
            avgRing[ringPtr] <= filtered;
        end
    end

    // A filter write restarts the running sum, since the old sum used another count.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ringPtr  <= 12'h000;
            avgSum   <= 36'h0;
            avgFill  <= 13'h0;
            avgOut   <= {DW{1'b0}};
            avgValid <= 1'b0;
        end else begin
            avgValid <= filtValid;
            if (filtValid) begin
                ringPtr <= ringPtr + 12'h001;
                avgOut  <= meanFull[DW-1:0];                                  // [RULE_15] [RULE_16]
            end
            if (avgClear) begin
                avgSum  <= 36'h0;
                avgFill <= 13'h0;
            end else if (filtValid) begin
                avgSum <= nextSum;                                            // [RULE_16]
                if (avgFill < avgCount) begin
                    avgFill <= avgFill + 13'h1;
                end
            end
        end
    end

    msf_fifo #(
        .WIDTH (DW),
        .DEPTH (`MSF_FIFO_DEPTH),
        .AW    (3)
    ) msf_fifo_inst (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .inValid  (avgValid),
        .inReady  (fifoInReady),
        .inData   (avgOut),
        .outValid (resultValid),
        .outReady (resultReady),
        .outData  (resultData)
    );
endmodule // msf_core

// [rtl/msf_defs.vh]
/*
 * Constants for the measurement sequencing and filter block: register offsets,
 * field positions, reset values and cycle figures.
 * Assumes inclusion by bare name from files under rtl/.
 */
// Notes on behaviour
// RULE_01: Static two-surface mode sweeps emission; cycle becomes about 76 regular cycles; code scales it down for an upper bound below 20 percent.
// RULE_02: Static two-surface mode forces auto emission upper bound to 20 percent; code caps it at 20 percent and keeps a lower setting.
// RULE_03: Emission bounds settable 0.1 to 80 percent; reset lower 0.1, upper 80.
// RULE_04: Staggering is off whenever thickness or spacing measurement is selected.
// RULE_05: Moving two-surface mode regulates intensity separately per surface section.
// RULE_06: Finishing moving-mode setup runs teaching; success derives section areas.
// RULE_07: Failed teaching assigns the whole measurement area.
// RULE_08: Staggering off after reset; when on, selects emission slot first or second.
// RULE_09: Staggering lengthens cycle 8 times, or 15 times in fast sensing.
// RULE_10: Both staggered controllers need identical sensing mode and conditions.
// RULE_11: Effective measurement cycle length is readable by software.
// RULE_12: Sensor gain steps 1 to 5, reset 1.
// RULE_13: Spike filter on at reset outputs median of last 15 values.
// RULE_14: Spike filter off passes values straight through.
// RULE_15: Averaging count power of two 1 to 4096, reset 128.
// RULE_16: Averager takes spike filter output, running mean every cycle.
`ifndef MSF_DEFS_VH
`define MSF_DEFS_VH

`define MSF_REG_CTRL        4'h0
`define MSF_REG_LASER       4'h1
`define MSF_REG_GAIN        4'h2
`define MSF_REG_FILTER      4'h3
`define MSF_REG_AREA        4'h4
`define MSF_REG_CYCLE       4'h5
`define MSF_REG_STATUS      4'h6
`define MSF_REG_RESULT      4'h7

`define MSF_CTRL_OBJ_LSB    0
`define MSF_CTRL_SYNC_ON    2
`define MSF_CTRL_SYNC_SLOT  3
`define MSF_CTRL_MODE_LSB   4
`define MSF_CTRL_TEACH      8
`define MSF_FLT_SMOOTH      0
`define MSF_FLT_AVG_LSB     4

`define MSF_OBJ_NORMAL      2'h0
`define MSF_OBJ_DEPTH_STOP  2'h1
`define MSF_OBJ_DEPTH_MOVE  2'h2

`define MSF_MODE_BASELINE   3'h0
`define MSF_MODE_FINE       3'h1
`define MSF_MODE_WEAK       3'h2
`define MSF_MODE_FAST       3'h3
`define MSF_MODE_USER       3'h4

`define MSF_LASER_MIN       10'h001
`define MSF_LASER_MAX       10'h320
`define MSF_LASER_SWEEP_MAX 10'h0c8
`define MSF_GAIN_MIN        3'h1
`define MSF_GAIN_MAX        3'h5
`define MSF_AVG_LOG_RST     4'h7
`define MSF_AVG_LOG_MAX     4'hc
`define MSF_SMOOTH_RST      1'h1

`define MSF_SWEEP_FACTOR    8'h4c
`define MSF_SYNC_FACTOR     8'h08
`define MSF_SYNC_FACT_FAST  8'h0f
`define MSF_MEDIAN_DEPTH    15
`define MSF_FIFO_DEPTH      8
`define MSF_DATA_W          24

`endif

// [rtl/msf_fifo.v]
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module msf_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,
    input  wire             rst_b,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = store[rdPtr];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge clk_sys) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // msf_fifo

// [tb/msf_front_model.sv]
/* Front end and output stage model: queued raw samples, teaching answers,
   a result sink that stalls one cycle in four. Assumes clk_sys and rst_b. */
`timescale 1ns/100ps
module msf_front_model (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        sampleReady,
    output reg         sampleValid,
    output reg  [23:0] sampleData,
    input  wire        teachStart,
    output reg         teachDone,
    output reg         teachOk,
    output reg  [9:0]  teachSplit,
    input  wire        teachPass,
    input  wire        resultValid,
    output reg         resultReady,
    input  wire [23:0] resultData,
    output reg  [23:0] lastResult,
    output integer     resultCount
);
    reg [23:0] q[$];
    reg [3:0]  tcnt;
    reg [1:0]  stall;
    task send(input [23:0] v);
        q.push_back(v);
    endtask
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sampleValid <= 1'b0;
            sampleData <= 24'h000000;
            {teachDone, teachOk, tcnt, stall, resultReady} <= 9'h000;
            teachSplit <= 10'h155;
            lastResult <= 24'h000000;
            resultCount <= 0;
        end else begin
            // Idle data lines toggle so a stale value is never mistaken for a sample.
            if (!sampleValid || sampleReady) begin
                sampleValid <= (q.size() > 0);
                sampleData <= (q.size() > 0) ? q.pop_front() : ~sampleData;
            end
            stall <= stall + 2'h1;
            resultReady <= (stall != 2'h3);
            if (resultValid && resultReady) begin
                lastResult <= resultData;
                resultCount <= resultCount + 1;
            end
            tcnt <= teachStart ? 4'h5 : (tcnt != 4'h0) ? tcnt - 4'h1 : 4'h0;
            teachDone <= (tcnt == 4'h1);
            teachOk <= teachPass;
        end
    end
endmodule // msf_front_model

// [tb/msf_core_properties.sv]
/* Port checker for msf_core, bound after the module.
   Assumes the single clock clk_sys and reset rst_b. */
`timescale 1ns/100ps
module msf_core_properties (
    input wire        clk_sys,
    input wire        rst_b,
    input wire        avsRead,
    input wire        avsWrite,
    input wire        avsWaitRequest,
    input wire        teachDone,
    input wire        teachOk,
    input wire [9:0]  teachSplit,
    input wire [9:0]  laserLower,
    input wire [9:0]  laserUpper,
    input wire        laserSweep,
    input wire        sectionMode,
    input wire [9:0]  sectionSplit,
    input wire        staggerOn,
    input wire [2:0]  sensorGain,
    input wire        resultValid,
    input wire        resultReady,
    input wire [23:0] resultData
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    depth_no_stagger_a: assert property ((laserSweep || sectionMode) |-> !staggerOn)
        else $error("stagger active in two-surface mode");
    sweep_upper_a: assert property (laserSweep |-> laserUpper <= 10'h0c8)
        else $error("sweep upper bound above limit");
    laser_range_a: assert property (laserLower >= 10'h001 && laserUpper <= 10'h320)
        else $error("emission bound out of range");
    gain_range_a: assert property (sensorGain >= 3'h1 && sensorGain <= 3'h5)
        else $error("gain step out of range");
    bus_answer_a: assert property ((avsRead || avsWrite) |-> ##[0:1] !avsWaitRequest)
        else $error("bus answer late");
    reset_state_a: assert property ($rose(rst_b) |-> sensorGain == 3'h1 && !staggerOn)
        else $error("wrong state after reset");
    teach_pass_a: assert property (teachDone && teachOk |-> ##[1:2] sectionSplit == teachSplit)
        else $error("section split not taken");
    teach_fail_a: assert property (teachDone && !teachOk |-> ##[1:2] !sectionMode)
        else $error("sections kept after failed teaching");
    result_hold_a: assert property (resultValid && !resultReady |=>
        resultValid && $stable(resultData))
        else $error("stalled result dropped");
endmodule // msf_core_properties
bind msf_core msf_core_properties msf_core_properties_inst (.*);

// [tb/tb_top.sv]
/* Self-checking bench for msf_core with the front end model.
   Assumes 250 MHz clk_sys and the register map of msf_defs.vh. */
`timescale 1ns/100ps
`include "msf_defs.vh"
module tb_top;
    logic clk_sys = 0, rst_b = 0, avsRead = 0, avsWrite = 0, teachPass = 1;
    logic [3:0] avsAddress = 4'h0, avsByteEnable = 4'hf;
    logic [31:0] avsWriteData = 32'h0, rd;
    logic [15:0] regularCycle = 16'h0064; // Both staggered heads share this setting.
    wire [31:0] avsReadData;
    wire avsWaitRequest, sampleValid, sampleReady, teachStart, teachDone, teachOk;
    wire laserSweep, sectionMode, staggerOn, staggerSlot, resultValid, resultReady;
    wire [23:0] sampleData, resultData, lastResult;
    wire [9:0] teachSplit, laserLower, laserUpper, sectionSplit;
    wire [2:0] sensorGain;
    integer resultCount, fail_count = 0, n_checks = 0, i;
    msf_core msf_core_inst (.*);
    msf_front_model msf_front_model_inst (.*);
    initial forever #2 clk_sys = ~clk_sys;
    task chk(input [31:0] got, input [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // The request stands from just after a rising edge until the edge that sees waitrequest low.
    task bus(input logic isRd, input logic [3:0] a, input logic [31:0] d);
        integer n;
        @(posedge clk_sys);
        {avsAddress, avsRead, avsWrite, avsWriteData} <= {a, isRd, !isRd, d};
        n = 0;
        @(posedge clk_sys);
        while (avsWaitRequest !== 1'b0) begin
            if (++n > 50) begin fail_count++; final_report; end
            @(posedge clk_sys);
        end
        rd = avsReadData;
        {avsRead, avsWrite} <= 2'b00;
        // Derived outputs settle one edge after the write lands.
        repeat (2) @(negedge clk_sys);
    endtask
    task waitRes(input integer n);
        integer t, k;
        t = resultCount + n;
        for (k = 0; resultCount < t; k++) begin
            @(posedge clk_sys);
            if (k > 3000) begin fail_count++; final_report; end
        end
        @(negedge clk_sys);
    endtask
    task t_reset;
        chk(laserLower, 10'h001);
        chk(laserUpper, 10'h320);
        chk(sensorGain, 3'h1);
        chk(staggerOn, 1'b0);
        bus(1, `MSF_REG_FILTER, 0);
        chk(rd & 32'hff, 32'h71);
        $display("test reset done");
    endtask
    task t_gain;
        for (i = 1; i <= 5; i++) begin
            bus(0, `MSF_REG_GAIN, i);
            chk(sensorGain, i);
        end
        bus(0, `MSF_REG_GAIN, 32'h7);
        chk(sensorGain, 3'h5);
        $display("test gain done");
    endtask
    task t_stagger;
        for (i = 0; i < 4; i++) begin
            bus(0, `MSF_REG_CTRL, 32'h0c | (i << 4));
            chk({staggerOn, staggerSlot}, 2'b11);
            bus(1, `MSF_REG_CYCLE, 0);
            chk(rd, (i == 3) ? 32'h5dc : 32'h320);
        end
        bus(0, `MSF_REG_CTRL, 32'h04);
        chk({staggerOn, staggerSlot}, 2'b10);
        $display("test stagger done");
    endtask
    task t_depth;
        bus(0, `MSF_REG_CTRL, 32'h0d);
        chk({staggerOn, laserSweep}, 2'b01);
        chk(laserUpper, 10'h0c8);
        bus(1, `MSF_REG_CYCLE, 0);
        chk(rd, 32'h1db0);
        bus(0, `MSF_REG_LASER, 32'h00640000);
        chk(laserLower, 10'h001);
        chk(laserUpper, 10'h064);
        bus(1, `MSF_REG_CYCLE, 0);
        chk(rd, 32'hed8);
        $display("test static depth done");
    endtask
    task t_teach(input logic p);
        integer k;
        teachPass <= p;
        bus(0, `MSF_REG_CTRL, 32'h106);
        for (k = 0; teachDone !== 1'b1; k++) begin
            @(negedge clk_sys);
            if (k > 100) begin fail_count++; final_report; end
        end
        repeat (3) @(negedge clk_sys);
        chk({staggerOn, sectionMode}, {1'b0, p});
        if (p) chk(sectionSplit, 10'h155);
        $display("test teaching done");
    endtask
    task t_filter;
        bus(0, `MSF_REG_FILTER, 32'h00);
        for (i = 5; i < 8; i++) msf_front_model_inst.send(i);
        waitRes(3);
        chk(lastResult, 24'h7);
        bus(0, `MSF_REG_FILTER, 32'h01);
        for (i = 0; i < 15; i++) msf_front_model_inst.send((i % 4 == 3) ? 24'hffffff : i * 2);
        waitRes(15);
        chk(lastResult, 24'h12);
        bus(0, `MSF_REG_FILTER, 32'h20);
        for (i = 0; i < 8; i++) msf_front_model_inst.send((i < 4) ? 0 : (i == 7) ? 80 : 40);
        waitRes(8);
        chk(lastResult, 24'h32);
        bus(0, `MSF_REG_FILTER, 32'hc0);
        bus(1, `MSF_REG_FILTER, 0);
        chk(rd & 32'hff, 32'hc0);
        $display("test filter done");
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        t_reset;
        t_gain;
        t_stagger;
        t_depth;
        t_teach(1'b1);
        t_teach(1'b0);
        t_filter;
        bus(1, 4'hf, 0);
        final_report;
    end
    initial begin
        #300000;
        fail_count++;
        final_report;
    end
endmodule // tb_top
